//--- sacs_defs.svh
`ifndef SACS_DEFS_SVH
`define SACS_DEFS_SVH

// Register byte offsets
`define SACS_REG_CTRL     4'h0
`define SACS_REG_STATUS   4'h4
`define SACS_REG_RESULT   4'h8

// Control register: variant field in bits [1:0], reset to the eight-input variant
`define SACS_CTRL_VAR_LSB 0
`define SACS_CTRL_VAR_MSB 1
`define SACS_CTRL_RST     2'h3

// Approximation register
`define SACS_SAR_INIT     8'h80
`define SACS_SAR_TOP      3'h7

// Negative input code for the grounded common line
`define SACS_NEG_COMMON   4'h8

// Timing
`define SACS_CLK_MHZ      10
`define SACS_DESELECT_NS  1000
`define SACS_DESEL_CYC    5'(((`SACS_DESELECT_NS * `SACS_CLK_MHZ) + 999) / 1000)

`endif

//--- sacs_pkg.sv
package sacs_pkg;

    typedef enum logic [2:0] {
        st_wait   = 3'b000,
        st_addr   = 3'b001,
        st_settle = 3'b010,
        st_conv   = 3'b011,
        st_lsb    = 3'b100,
        st_tail   = 3'b101
    } sacs_state_t;

    typedef enum logic [1:0] {
        var_1ch = 2'b00,
        var_2ch = 2'b01,
        var_4ch = 2'b10,
        var_8ch = 2'b11
    } sacs_variant_t;

endpackage

//--- sacs_csr.sv
`timescale 1ns/1ps
`include "sacs_defs.svh"

module sacs_csr (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    // Register bus
    input  wire logic [3:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    // Block side
    input  wire logic [31:0]            status_word,
    input  wire logic [7:0]             result_word,
    output sacs_pkg::sacs_variant_t     variant
);

    logic                    wait_q;
    logic                    wait_d;
    logic [31:0]             rd_q;
    logic [31:0]             rd_d;
    sacs_pkg::sacs_variant_t var_q;
    sacs_pkg::sacs_variant_t var_d;

    function automatic logic [31:0] reg_read(input logic [3:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == `SACS_REG_CTRL) begin
            v = {30'h0000_0000, var_q};
        end else if (a == `SACS_REG_STATUS) begin
            v = status_word;
        end else if (a == `SACS_REG_RESULT) begin
            v = {24'h00_0000, result_word};
        end
        return v;
    endfunction

    // One wait cycle per access; data and write land with waitrequest low
    always_comb begin
        wait_d = ~((avs_read | avs_write) & wait_q);
        rd_d   = rd_q;
        var_d  = var_q;
        if (avs_read && wait_q) begin
            rd_d = reg_read(avs_address);
        end
        if (avs_write && !wait_q && avs_address == `SACS_REG_CTRL && avs_byteenable[0]) begin
            var_d = sacs_pkg::sacs_variant_t'(avs_writedata[`SACS_CTRL_VAR_MSB:`SACS_CTRL_VAR_LSB]);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 1'b1;
            rd_q   <= 32'h0000_0000;
            var_q  <= sacs_pkg::sacs_variant_t'(`SACS_CTRL_RST);
        end else begin
            wait_q <= wait_d;
            rd_q   <= rd_d;
            var_q  <= var_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rd_q;
    assign variant         = var_q;

endmodule

//--- sacs_sequencer.sv
// Summary of operation
// - Sample input each rise; first one starts
// - None (single-input) or two to four address bits follow start
// - Half-period settling gap after address
// - Flag rises at settling; input then ignored
// - Output enabled, leading zero at end of settling
// - Decided bits out on falling edges, MSB first
// - Eight periods; flag drops half later
// - Result copied into output shift register
// - Eight-input: shift-enable low shifts LSB first
// - Two- and four-input shift LSB first automatically after MSB
// - After data, output low until deselect
// - Single-input variant gives MSB first only
// - Deselect past hold time clears all but result and last address
// - Input sampled only while output floats
// - Four-input single-ended codes pick 0,2,1,3
// - Address word reconfigures each conversion
// - Unsigned eight-bit code, 256 steps
// - Differential mode uses adjacent pair, polarity
// - Negative input higher yields all zeros
`timescale 1ns/1ps
`include "sacs_defs.svh"

module sacs_sequencer (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Register bus
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Serial link
    input  wire logic        sel_n,
    input  wire logic        conv_clk,
    input  wire logic        serial_in_line,
    input  wire logic        lsb_shift_enable_n,
    output logic             serial_out,
    output logic             serial_out_oe,
    output logic             conversion_active_flag,
    // Analog front end
    input  wire logic        comp_in,
    output logic [2:0]       mux_pos_ch,
    output logic [3:0]       mux_neg_ch
);

    sacs_pkg::sacs_variant_t variant;
    sacs_pkg::sacs_state_t   state_q;
    sacs_pkg::sacs_state_t   state_d;
    logic                    cclk_q;
    logic                    rise;
    logic                    fall;
    logic [4:0]              desel_q;
    logic [4:0]              desel_d;
    logic                    desel_done;
    logic [2:0]              alen;
    logic [3:0]              addr_q;
    logic [3:0]              addr_d;
    logic [2:0]              acnt_q;
    logic [2:0]              acnt_d;
    logic [7:0]              sar_q;
    logic [7:0]              sar_d;
    logic [2:0]              idx_q;
    logic [2:0]              idx_d;
    logic                    bit_q;
    logic                    bit_d;
    logic [7:0]              shreg_q;
    logic [7:0]              shreg_d;
    logic [2:0]              lcnt_q;
    logic [2:0]              lcnt_d;
    logic                    so_q;
    logic                    so_d;
    logic                    oe_q;
    logic                    oe_d;
    logic                    act_q;
    logic                    act_d;
    logic [2:0]              pos_q;
    logic [2:0]              pos_d;
    logic [3:0]              neg_q;
    logic [3:0]              neg_d;
    logic [7:0]              result_q;
    logic [7:0]              result_d;
    logic [3:0]              alast_q;
    logic [3:0]              alast_d;

    sacs_csr u_csr (
        .ref_clk         (ref_clk),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .status_word     ({9'h000, neg_q, pos_q, act_q, state_q, alast_q, result_q}),
        .result_word     (result_q),
        .variant         (variant)
    );

    // Number of address bits after the start bit
    function automatic logic [2:0] addr_len(input logic [1:0] v);
        logic [2:0] n;
        n = 3'h0;
        unique case (v)
            sacs_pkg::var_1ch: n = 3'h0;
            sacs_pkg::var_2ch: n = 3'h2;
            sacs_pkg::var_4ch: n = 3'h3;
            sacs_pkg::var_8ch: n = 3'h4;
        endcase
        return n;
    endfunction

    // Address word to {positive channel, negative channel}
    function automatic logic [6:0] mux_decode(input logic [1:0] v, input logic [3:0] a);
        logic       sgl;
        logic       odd;
        logic [1:0] sel;
        logic [2:0] pos;
        sgl = 1'b0;
        odd = 1'b0;
        sel = 2'h0;
        unique case (v)
            sacs_pkg::var_1ch: sgl = 1'b0;
            sacs_pkg::var_2ch: {sgl, odd} = a[1:0];
            sacs_pkg::var_4ch: {sgl, odd, sel[0]} = a[2:0];
            sacs_pkg::var_8ch: {sgl, odd, sel} = a;
        endcase
        pos = {sel, odd};
        if (sgl) begin
            return {pos, `SACS_NEG_COMMON};
        end
        return {pos, {1'b0, sel, ~odd}};
    endfunction

    // Link clock edges, taken only while selected
    assign rise       = conv_clk & ~cclk_q & ~sel_n;
    assign fall       = ~conv_clk & cclk_q & ~sel_n;
    assign desel_done = sel_n && (desel_q == `SACS_DESEL_CYC);
    assign alen       = addr_len(variant);

    // Deselect timer
    always_comb begin
        desel_d = desel_q;
        if (!sel_n) begin
            desel_d = 5'h00;
        end else if (desel_q != `SACS_DESEL_CYC) begin
            desel_d = desel_q + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            desel_q <= 5'h00;
            cclk_q  <= 1'b0;
        end else begin
            desel_q <= desel_d;
            cclk_q  <= conv_clk;
        end
    end

    // Conversion sequencer
    always_comb begin
        state_d  = state_q;
        addr_d   = addr_q;
        acnt_d   = acnt_q;
        sar_d    = sar_q;
        idx_d    = idx_q;
        bit_d    = bit_q;
        shreg_d  = shreg_q;
        lcnt_d   = lcnt_q;
        so_d     = so_q;
        oe_d     = oe_q;
        act_d    = act_q;
        pos_d    = pos_q;
        neg_d    = neg_q;
        result_d = result_q;
        alast_d  = alast_q;
        if (desel_done) begin
            state_d = sacs_pkg::st_wait;
            addr_d  = 4'h0;
            acnt_d  = 3'h0;
            sar_d   = 8'h00;
            idx_d   = 3'h0;
            bit_d   = 1'b0;
            shreg_d = 8'h00;
            lcnt_d  = 3'h0;
            so_d    = 1'b0;
            oe_d    = 1'b0;
            act_d   = 1'b0;
            pos_d   = 3'h0;
            neg_d   = 4'h0;
        end else begin
            unique case (state_q)
                sacs_pkg::st_wait: begin
                    if (rise && serial_in_line) begin
                        addr_d = 4'h0;
                        acnt_d = 3'h0;
                        if (alen == 3'h0) begin
                            state_d        = sacs_pkg::st_settle;
                            act_d          = 1'b1;
                            {pos_d, neg_d} = mux_decode(variant, 4'h0);
                        end else begin
                            state_d = sacs_pkg::st_addr;
                        end
                    end
                end
                sacs_pkg::st_addr: begin
                    if (rise) begin
                        addr_d = {addr_q[2:0], serial_in_line};
                        acnt_d = acnt_q + 3'h1;
                        if (acnt_q == alen - 3'h1) begin
                            state_d        = sacs_pkg::st_settle;
                            act_d          = 1'b1;
                            alast_d        = addr_d;
                            {pos_d, neg_d} = mux_decode(variant, addr_d);
                        end
                    end
                end
                sacs_pkg::st_settle: begin
                    if (fall) begin
                        oe_d    = 1'b1;
                        so_d    = 1'b0;
                        sar_d   = `SACS_SAR_INIT;
                        idx_d   = `SACS_SAR_TOP;
                        state_d = sacs_pkg::st_conv;
                    end
                end
                sacs_pkg::st_conv: begin
                    if (rise) begin
                        bit_d        = comp_in;
                        sar_d[idx_q] = comp_in;
                        if (idx_q != 3'h0) begin
                            sar_d[idx_q - 3'h1] = 1'b1;
                        end
                    end else if (fall) begin
                        so_d = bit_q;
                        if (idx_q == 3'h0) begin
                            shreg_d  = sar_q;
                            result_d = sar_q;
                            lcnt_d   = 3'h1;
                            if (variant == sacs_pkg::var_1ch) begin
                                state_d = sacs_pkg::st_tail;
                            end else begin
                                state_d = sacs_pkg::st_lsb;
                            end
                        end else begin
                            idx_d = idx_q - 3'h1;
                        end
                    end
                end
                sacs_pkg::st_lsb: begin
                    if (fall && (variant != sacs_pkg::var_8ch || !lsb_shift_enable_n)) begin
                        if (lcnt_q == 3'h0) begin
                            so_d    = 1'b0;
                            state_d = sacs_pkg::st_tail;
                        end else begin
                            so_d   = shreg_q[lcnt_q];
                            lcnt_d = lcnt_q + 3'h1;
                        end
                    end
                end
                sacs_pkg::st_tail: begin
                    if (fall) begin
                        so_d = 1'b0;
                    end
                end
                default: begin
                    state_d = sacs_pkg::st_wait;
                end
            endcase
            if (rise && (state_q == sacs_pkg::st_lsb || state_q == sacs_pkg::st_tail)) begin
                act_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= sacs_pkg::st_wait;
            addr_q   <= 4'h0;
            acnt_q   <= 3'h0;
            sar_q    <= 8'h00;
            idx_q    <= 3'h0;
            bit_q    <= 1'b0;
            shreg_q  <= 8'h00;
            lcnt_q   <= 3'h0;
            so_q     <= 1'b0;
            oe_q     <= 1'b0;
            act_q    <= 1'b0;
            pos_q    <= 3'h0;
            neg_q    <= 4'h0;
            result_q <= 8'h00;
            alast_q  <= 4'h0;
        end else begin
            state_q  <= state_d;
            addr_q   <= addr_d;
            acnt_q   <= acnt_d;
            sar_q    <= sar_d;
            idx_q    <= idx_d;
            bit_q    <= bit_d;
            shreg_q  <= shreg_d;
            lcnt_q   <= lcnt_d;
            so_q     <= so_d;
            oe_q     <= oe_d;
            act_q    <= act_d;
            pos_q    <= pos_d;
            neg_q    <= neg_d;
            result_q <= result_d;
            alast_q  <= alast_d;
        end
    end

    assign serial_out             = so_q;
    assign serial_out_oe          = oe_q;
    assign conversion_active_flag = act_q;
    assign mux_pos_ch             = pos_q;
    assign mux_neg_ch             = neg_q;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_addr_done;
        state_q == sacs_pkg::st_addr && rise && acnt_q == alen - 3'h1;
    endsequence

    sequence s_settling;
        state_q == sacs_pkg::st_settle && conversion_active_flag && !serial_out_oe;
    endsequence

    a_addr_to_settle: assert property (s_addr_done |=> s_settling)
        else $error("Settling gap not entered after address");
    a_start_bit_seen: assert property (state_q == sacs_pkg::st_wait && rise && serial_in_line
        |=> state_q != sacs_pkg::st_wait)
        else $error("Start bit missed");
    a_flag_rise_settle: assert property ($rose(conversion_active_flag) |-> state_q == sacs_pkg::st_settle)
        else $error("Flag rose outside settling");
    a_input_closed: assert property (serial_out_oe
        |-> !(state_q inside {sacs_pkg::st_wait, sacs_pkg::st_addr}))
        else $error("Output driven during addressing");
    a_lead_zero: assert property ($rose(serial_out_oe) |-> !serial_out && state_q == sacs_pkg::st_conv)
        else $error("No leading zero");
    a_bit_on_fall: assert property (serial_out_oe && $changed(serial_out) |-> $past(fall))
        else $error("Output changed off a falling edge");
    a_flag_fall_half: assert property ($fell(conversion_active_flag) && !$past(desel_done)
        |-> $past(rise) && state_q inside {sacs_pkg::st_lsb, sacs_pkg::st_tail})
        else $error("Flag fell at wrong time");
    a_result_copied: assert property (state_q == sacs_pkg::st_lsb |-> shreg_q == result_q)
        else $error("Shift register not loaded");
    a_lsb_hold: assert property (state_q == sacs_pkg::st_lsb && variant == sacs_pkg::var_8ch
        && lsb_shift_enable_n && !sel_n |=> $stable(serial_out))
        else $error("LSB not held");
    a_single_msb_only: assert property (variant == sacs_pkg::var_1ch && $past(variant) == sacs_pkg::var_1ch
        |-> state_q != sacs_pkg::st_lsb)
        else $error("LSB stream on single-input variant");
    a_tail_low: assert property (state_q == sacs_pkg::st_tail && (fall || !serial_out) |=> !serial_out)
        else $error("Output not low after data");
    a_deselect_clear: assert property (desel_done
        |=> state_q == sacs_pkg::st_wait && !serial_out_oe && !conversion_active_flag)
        else $error("Deselect did not clear");
    a_single_ended_map: assert property ($rose(conversion_active_flag) && variant == sacs_pkg::var_4ch && addr_q[2]
        |-> mux_neg_ch == `SACS_NEG_COMMON && mux_pos_ch == {1'b0, addr_q[0], addr_q[1]})
        else $error("Single-ended channel map wrong");
    a_sar_step: assert property (state_q == sacs_pkg::st_conv && rise && !sel_n
        |=> sar_q[$past(idx_q)] == $past(comp_in))
        else $error("Approximation bit not taken from comparator");

endmodule

//--- sacs_ctrl_model.sv
`timescale 1ns/1ps

module sacs_ctrl_model (
    // Clock
    input  wire logic ref_clk,
    // Serial link
    output logic      sel_n,
    output logic      conv_clk,
    output logic      serial_in_line,
    output logic      lsb_shift_enable_n,
    input  wire logic serial_out,
    input  wire logic serial_out_oe,
    input  wire logic conversion_active_flag,
    // Comparator
    output logic      comp_in
);
    logic drift;

    initial begin
        sel_n = 1'b1;
        conv_clk = 1'b0;
        serial_in_line = 1'b0;
        lsb_shift_enable_n = 1'b1;
        comp_in = 1'b0;
        drift = 1'b0;
    end

    // One converter clock phase; a released data line toggles every phase
    task automatic half(input logic v);
        conv_clk <= v;
        if (drift) serial_in_line <= ~serial_in_line;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic convert(input int nb, input logic [3:0] a, input logic [7:0] t, input int lead, input int hold,
                           output logic [2:0] st, output logic [7:0] msb, output logic fl_end,
                           output logic [7:0] lsb, output logic hold_ok, output logic [1:0] tail);
        sel_n <= 1'b0;
        lsb_shift_enable_n <= 1'b1;
        repeat (lead) begin
            serial_in_line <= 1'b0;
            half(1'b0);
            half(1'b1);
        end
        serial_in_line <= 1'b1;
        half(1'b0);
        half(1'b1);
        for (int i = 0; i < nb; i++) begin
            serial_in_line <= a[nb - 1 - i];
            half(1'b0);
            half(1'b1);
        end
        drift = 1'b1;
        half(1'b0);
        st = {conversion_active_flag, serial_out_oe, serial_out};
        for (int k = 7; k >= 0; k--) begin
            comp_in <= t[k];
            half(1'b1);
            half(1'b0);
            msb[k] = serial_out;
        end
        half(1'b1);
        fl_end = conversion_active_flag;
        hold_ok = 1'b1;
        lsb = {7'h00, msb[0]};
        repeat (hold) begin
            half(1'b0);
            hold_ok &= (serial_out === t[0]);
            half(1'b1);
        end
        if (nb == 4) lsb_shift_enable_n <= 1'b0;
        if (nb > 0) begin
            for (int j = 1; j < 8; j++) begin
                half(1'b0);
                lsb[j] = serial_out;
                half(1'b1);
            end
        end
        half(1'b0);
        tail = {serial_out_oe, serial_out};
    endtask

    // Deselect long enough to clear; the converter clock stands still
    task automatic deselect();
        sel_n <= 1'b1;
        drift = 1'b0;
        serial_in_line <= 1'b0;
        repeat (12) @(posedge ref_clk);
    endtask
endmodule

//--- sacs_sequencer_tb.sv
`timescale 1ns/1ps

module sacs_sequencer_tb;
    logic        ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic        sel_n, conv_clk, serial_in_line, lsb_shift_enable_n, serial_out, serial_out_oe;
    logic        conversion_active_flag, comp_in;
    logic [2:0]  mux_pos_ch;
    logic [3:0]  mux_neg_ch;
    int          n_fail, cmp_count, cyc;

    sacs_sequencer dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sel_n(sel_n), .conv_clk(conv_clk),
        .serial_in_line(serial_in_line), .lsb_shift_enable_n(lsb_shift_enable_n), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .conversion_active_flag(conversion_active_flag), .comp_in(comp_in),
        .mux_pos_ch(mux_pos_ch), .mux_neg_ch(mux_neg_ch));

    sacs_ctrl_model mdl (.ref_clk(ref_clk), .sel_n(sel_n), .conv_clk(conv_clk), .serial_in_line(serial_in_line),
        .lsb_shift_enable_n(lsb_shift_enable_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .conversion_active_flag(conversion_active_flag), .comp_in(comp_in));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Expected positive and negative channel for a variant and address word
    function automatic logic [6:0] exp_mux(input int v, input logic [3:0] a);
        logic       sgl;
        logic       odd;
        logic [1:0] sel;
        if (v == 0) return {3'h0, 4'h1};
        sgl = a[v];
        odd = a[v - 1];
        sel = (v == 3) ? a[1:0] : (v == 2) ? {1'b0, a[0]} : 2'b00;
        return {sel, odd, sgl ? 4'h8 : {1'b0, sel, ~odd}};
    endfunction

    task automatic run_conv(input int v, input logic [3:0] a, input logic [7:0] t, input int lead, input int hold);
        logic [2:0]  st;
        logic [7:0]  msb, lsb;
        logic        fe, hk;
        logic [1:0]  tl;
        logic [31:0] q;
        mdl.convert((v == 0) ? 0 : v + 1, a, t, lead, hold, st, msb, fe, lsb, hk, tl);
        check(st, 3'b110);
        check(msb, t);
        check(fe, 1'b0);
        if (v != 0) check(lsb, t);
        check(hk, 1'b1);
        check(tl, 2'b10);
        check({mux_pos_ch, mux_neg_ch}, exp_mux(v, a));
        avs(1'b0, 4'h4, 32'h0, 4'hf, q);
        check(q[7:0], t);
        if (v != 0) check(q[11:8], a);
        avs(1'b0, 4'h8, 32'h0, 4'hf, q);
        check(q, {24'h00_0000, t});
        mdl.deselect();
        check({serial_out_oe, conversion_active_flag}, 2'b00);
    endtask

    initial begin
        int          nb;
        logic [3:0]  a, mask;
        logic [7:0]  t;
        logic [31:0] q;
        reset_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        void'($urandom(32'h7d3a));
        check({serial_out_oe, conversion_active_flag}, 2'b00);
        avs(1'b0, 4'h0, 32'h0, 4'hf, q);
        check(q[1:0], 2'h3);
        avs(1'b0, 4'hc, 32'h0, 4'hf, q);
        check(q, 32'h0);
        avs(1'b1, 4'h0, 32'h0, 4'he, q);
        avs(1'b0, 4'h0, 32'h0, 4'hf, q);
        check(q[1:0], 2'h3);
        $display("test registers done");
        for (int v = 3; v >= 0; v--) begin
            avs(1'b1, 4'h0, 32'(v), 4'hf, q);
            nb = (v == 0) ? 0 : v + 1;
            mask = 4'((1 << nb) - 1);
            for (int i = 0; i < 6; i++) begin
                t = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
                a = (i < 4) ? (4'(1 << (nb - 1)) | 4'(i)) & mask : 4'($urandom) & mask;
                run_conv(v, a, t, i % 3, (v == 3 && i == 4) ? 2 : 0);
            end
            $display("test variant %0d done", v);
        end
        final_report();
    end
endmodule
